// file: rtl/scrd_decoder.sv
// command register decoder with unlock sequences and soft reset
// Overview of operation
// - reads of the command register always return zero
// - 0x5D then 0xA0 as next command triggers memory write
// - 0x5D then 0xA5 as next command triggers memory read
// - wrong second step after 0x5D discards the memory sequence
// - 0x73, 0xB4, 0x69 in order enables extended mode
// - wrong command mid extended sequence restarts tracking from beginning
// - paging enable bit cleared in page select register leaves extended mode, unless 0x69 completes the extended sequence in the same cycle
// - 0xB6 resets all user configuration to defaults
// - reset command over I2C is not acknowledged
`timescale 1ns/100ps
`include "scrd_cfg.svh"
module scrd_decoder
   import scrd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input scrd_req_s req,
   input wire logic paging_en,
   input wire logic paging_en_wr,
   output logic [7:0] rdata,
   output logic i2c_ack_en,
   output logic page_select_register,
   output logic nvm_write_start,
   output logic nvm_read_start,
   output logic soft_reset
);
   scrd_state_s st_r;
   scrd_state_s st_nxt;
   logic cmd_wr;
   logic [7:0] c;

   assign cmd_wr = req.wr && (req.addr == `SCRD_CMD_ADDR);
   assign c = req.wdata;

   always_comb begin
      st_nxt = st_r;
      st_nxt.nvm_write = 1'h0;
      st_nxt.nvm_read = 1'h0;
      st_nxt.soft_reset = 1'h0;
      if (paging_en_wr && !paging_en) begin
         st_nxt.page_select_register = 1'h0;
      end
      if (cmd_wr) begin
         st_nxt.nvm_armed = (c == `SCRD_CMD_NVM_FIRST);
         if (st_r.nvm_armed && c == `SCRD_CMD_NVM_WRITE) begin
            st_nxt.nvm_write = 1'h1;
         end
         if (st_r.nvm_armed && c == `SCRD_CMD_NVM_READ) begin
            st_nxt.nvm_read = 1'h1;
         end
         case (st_r.ext_seq)
            SCRD_EXT_GOT1: begin
               st_nxt.ext_seq = (c == `SCRD_CMD_EXT_2) ? SCRD_EXT_GOT2 : SCRD_EXT_IDLE;
            end
            SCRD_EXT_GOT2: begin
               st_nxt.ext_seq = SCRD_EXT_IDLE;
               if (c == `SCRD_CMD_EXT_3) begin
                  st_nxt.page_select_register = 1'h1;
               end
            end
            default: begin
               st_nxt.ext_seq = SCRD_EXT_IDLE;
            end
         endcase
         if (c == `SCRD_CMD_EXT_1) begin
            st_nxt.ext_seq = SCRD_EXT_GOT1;
         end
         if (c == `SCRD_CMD_SOFT_RESET) begin
            st_nxt.soft_reset = 1'h1;
            st_nxt.nvm_armed = 1'h0;
            st_nxt.ext_seq = SCRD_EXT_IDLE;
            st_nxt.page_select_register = 1'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '{1'h0, SCRD_EXT_IDLE, 1'h0, 1'h0, 1'h0, 1'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = `SCRD_READ_VAL;
   assign i2c_ack_en = !(cmd_wr && c == `SCRD_CMD_SOFT_RESET);
   assign page_select_register = st_r.page_select_register;
   assign nvm_write_start = st_r.nvm_write;
   assign nvm_read_start = st_r.nvm_read;
   assign soft_reset = st_r.soft_reset;

   sequence nvm_arm_s;
      cmd_wr && c == `SCRD_CMD_NVM_FIRST;
   endsequence
   sequence nvm_wr_s;
      cmd_wr && c == `SCRD_CMD_NVM_WRITE;
   endsequence
   sequence nvm_rd_s;
      cmd_wr && c == `SCRD_CMD_NVM_READ;
   endsequence
   sequence ext_s1_s;
      cmd_wr && c == `SCRD_CMD_EXT_1;
   endsequence
   sequence ext_s2_s;
      cmd_wr && c == `SCRD_CMD_EXT_2;
   endsequence
   sequence ext_s3_s;
      cmd_wr && c == `SCRD_CMD_EXT_3;
   endsequence
   sequence srst_s;
      cmd_wr && c == `SCRD_CMD_SOFT_RESET;
   endsequence

   rdata_zero_a: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == `SCRD_CMD_ADDR |-> rdata == `SCRD_READ_VAL)
      else $error("command read not zero");

   nvm_write_go_a: assert property (@(posedge clk) disable iff (rst)
      nvm_arm_s ##1 nvm_wr_s |=> nvm_write_start)
      else $error("memory write not started");

   nvm_read_go_a: assert property (@(posedge clk) disable iff (rst)
      nvm_arm_s ##1 nvm_rd_s |=> nvm_read_start)
      else $error("memory read not started");

   nvm_write_cause_a: assert property (@(posedge clk) disable iff (rst)
      nvm_write_start |-> $past(st_r.nvm_armed) && $past(cmd_wr)
      && $past(c) == `SCRD_CMD_NVM_WRITE)
      else $error("memory write without arming");

   nvm_read_cause_a: assert property (@(posedge clk) disable iff (rst)
      nvm_read_start |-> $past(st_r.nvm_armed) && $past(cmd_wr)
      && $past(c) == `SCRD_CMD_NVM_READ)
      else $error("memory read without arming");

   nvm_abort_a: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && c != `SCRD_CMD_NVM_FIRST |=> !st_r.nvm_armed)
      else $error("memory sequence not discarded");

   other_addr_a: assert property (@(posedge clk) disable iff (rst)
      req.wr && req.addr != `SCRD_CMD_ADDR |=> $stable(st_r.nvm_armed)
      && $stable(st_r.ext_seq))
      else $error("write elsewhere taken as command");

   ext_enable_a: assert property (@(posedge clk) disable iff (rst)
      ext_s1_s ##1 ext_s2_s ##1 ext_s3_s |=> page_select_register)
      else $error("extended mode not entered");

   ext_step2_a: assert property (@(posedge clk) disable iff (rst)
      st_r.ext_seq == SCRD_EXT_GOT1 && cmd_wr && c == `SCRD_CMD_EXT_2
      |=> st_r.ext_seq == SCRD_EXT_GOT2)
      else $error("extended second step lost");

   ext_restart_a: assert property (@(posedge clk) disable iff (rst)
      st_r.ext_seq != SCRD_EXT_IDLE && cmd_wr && c != `SCRD_CMD_EXT_1
      && c != `SCRD_CMD_EXT_2 |=> st_r.ext_seq == SCRD_EXT_IDLE)
      else $error("extended tracking not restarted");

   ext_first_a: assert property (@(posedge clk) disable iff (rst)
      ext_s1_s |=> st_r.ext_seq == SCRD_EXT_GOT1)
      else $error("extended first step lost");

   ext_third_a: assert property (@(posedge clk) disable iff (rst)
      st_r.ext_seq == SCRD_EXT_GOT2 && cmd_wr && c != `SCRD_CMD_EXT_1
      |=> st_r.ext_seq == SCRD_EXT_IDLE)
      else $error("extended tracking not ended");

   ext_leave_a: assert property (@(posedge clk) disable iff (rst)
      paging_en_wr && !paging_en && !cmd_wr |=> !page_select_register)
      else $error("extended mode not left");

   ext_hold_a: assert property (@(posedge clk) disable iff (rst)
      !cmd_wr && !paging_en_wr |=> $stable(page_select_register))
      else $error("extended mode changed unprompted");

   soft_reset_a: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && c == `SCRD_CMD_SOFT_RESET |=> soft_reset && !page_select_register
      && !st_r.nvm_armed)
      else $error("soft reset incomplete");

   srst_cause_a: assert property (@(posedge clk) disable iff (rst)
      soft_reset |-> $past(cmd_wr) && $past(c) == `SCRD_CMD_SOFT_RESET)
      else $error("soft reset without command");

   no_ack_a: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && c == `SCRD_CMD_SOFT_RESET |-> !i2c_ack_en)
      else $error("reset command acknowledged");

   ack_level_a: assert property (@(posedge clk) disable iff (rst)
      !(cmd_wr && c == `SCRD_CMD_SOFT_RESET) |-> i2c_ack_en)
      else $error("byte not acknowledged");

   srst_track_a: assert property (@(posedge clk) disable iff (rst)
      srst_s |=> st_r.ext_seq == SCRD_EXT_IDLE && !st_r.nvm_armed)
      else $error("sequence tracking survived soft reset");
endmodule

// file: rtl/scrd_cfg.svh
// constants for the command register decoder
`ifndef SCRD_CFG_SVH
`define SCRD_CFG_SVH
`define SCRD_CMD_ADDR 8'h7e
`define SCRD_CMD_RESET_VAL 8'h00
`define SCRD_READ_VAL 8'h00
`define SCRD_CMD_NONE 8'h00
`define SCRD_CMD_NVM_FIRST 8'h5d
`define SCRD_CMD_NVM_WRITE 8'ha0
`define SCRD_CMD_NVM_READ 8'ha5
`define SCRD_CMD_EXT_1 8'h73
`define SCRD_CMD_EXT_2 8'hb4
`define SCRD_CMD_EXT_3 8'h69
`define SCRD_CMD_SOFT_RESET 8'hb6
`endif

// file: rtl/scrd_pkg.sv
// types for the command register decoder
package scrd_pkg;
   typedef enum logic [1:0] {
      SCRD_EXT_IDLE,
      SCRD_EXT_GOT1,
      SCRD_EXT_GOT2
   } scrd_ext_e;

   typedef struct packed {
      logic nvm_armed;
      scrd_ext_e ext_seq;
      logic page_select_register;
      logic nvm_write;
      logic nvm_read;
      logic soft_reset;
   } scrd_state_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scrd_req_s;
endpackage

// file: tb/scrd_host.sv
// host model issuing command register writes
`timescale 1ns/100ps
module scrd_host
   import scrd_pkg::*;
(
   input wire logic clk,
   input wire logic i2c_ack_en,
   input wire logic [7:0] rdata,
   output scrd_req_s req
);
   logic ack;
   logic [7:0] rd_data;
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{1'h1, 1'h0, a, d};
      @(posedge clk);
      ack = i2c_ack_en;
      #1;
   endtask
   // read strobe, data taken at the edge
   task automatic rd(input logic [7:0] a);
      req = '{1'h0, 1'h1, a, 8'h00};
      @(posedge clk);
      rd_data = rdata;
      #1;
   endtask
   // released lines show the inverse for one edge
   task automatic idle();
      req = '{1'h0, 1'h0, ~req.addr, ~req.wdata};
      @(posedge clk);
      #1;
   endtask
endmodule

// file: tb/sensor_command_register_decoder_tb.sv
// testbench for the command register decoder
`timescale 1ns/100ps
module sensor_command_register_decoder_tb import scrd_pkg::*;;
   logic clk = 0, rst = 1, pg_en = 1, pg_wr = 0;
   scrd_req_s req;
   logic [7:0] rdata;
   logic ack_en, ext, nw, nr, sr;
   int n_mismatch = 0, n_tests = 0;
   wire [7:0] st = {4'h0, sr, ext, nw, nr};
   scrd_host i_host(.clk(clk), .i2c_ack_en(ack_en), .rdata(rdata), .req(req));
   scrd_decoder i_dut(.clk(clk), .rst(rst), .req(req), .paging_en(pg_en),
      .paging_en_wr(pg_wr), .rdata(rdata), .i2c_ack_en(ack_en), .page_select_register(ext),
      .nvm_write_start(nw), .nvm_read_start(nr), .soft_reset(sr));
   initial forever #2 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic w(input logic [7:0] d);
      i_host.wr(8'h7e, d);
   endtask
   task automatic t_nvm();
      w(8'h5d);
      w(8'ha0);
      chk(st, 8'h02);
      chk({7'h00, i_host.ack}, 8'h01);
      w(8'h5d);
      w(8'ha5);
      chk(st, 8'h01);
      w(8'h5d);
      w(8'h73);
      w(8'ha0);
      chk(st, 8'h00);
      i_host.wr(8'h10, 8'h5d);
      w(8'ha0);
      chk(st, 8'h00);
      w(8'h5d);
      i_host.idle();
      i_host.wr(8'h10, 8'h00);
      w(8'ha5);
      chk(st, 8'h01);
      i_host.idle();
   endtask
   task automatic t_ext();
      w(8'h73);
      w(8'hb4);
      w(8'h69);
      chk(st, 8'h04);
      i_host.idle();
      pg_wr = 1;
      @(posedge clk);
      #1 pg_en = 0;
      chk(st, 8'h04);
      @(posedge clk);
      #1 pg_wr = 0;
      chk(st, 8'h00);
      w(8'h73);
      w(8'hb4);
      w(8'h5d);
      w(8'h69);
      chk(st, 8'h00);
      w(8'h73);
      w(8'hb4);
      w(8'h73);
      w(8'hb4);
      w(8'h69);
      chk(st, 8'h04);
      i_host.idle();
   endtask
   task automatic t_rst();
      w(8'h5d);
      w(8'hb6);
      chk({7'h00, i_host.ack}, 8'h00);
      chk(st, 8'h08);
      w(8'ha0);
      chk(st, 8'h00);
      w(8'h73);
      w(8'hb4);
      w(8'hb6);
      w(8'h69);
      chk(st, 8'h00);
      i_host.rd(8'h7e);
      chk(i_host.rd_data, 8'h00);
      i_host.idle();
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 0;
      t_nvm();
      t_ext();
      t_rst();
      tally_and_finish();
   end
   initial begin
      #4000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
